// >>> rtl/asc_chan.sv
// Purpose: one async serial channel with its register set
// Assumes: bus, modem and rx pins are asynchronous to clk_sys_in
// Notes:   bus strobes are acted on after a two-flop synchroniser
`timescale 1ns/1ps
module asc_chan (
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  input  wire logic                   ce_in,
  input  wire asc_pkg::asc_bus_in_t   bus_in,
  output logic [7:0]                  data_out,
  output logic                        data_oe_n_out,
  input  wire logic                   rx_in,
  output logic                        tx_out,
  input  wire asc_pkg::asc_modem_in_t modem_in,
  output logic                        dtr_n_out,
  output logic                        rts_n_out,
  output logic                        int_out,
  output logic                        int_oe_n_out
);
  import asc_pkg::*;

  asc_bus_in_t   bus_s1_q, bus_s2_q;
  asc_modem_in_t mdm_s1_q, mdm_s2_q;
  logic          rx_s1_q, rx_s2_q, rd_n_s3_q, wr_n_s3_q;
  logic [7:0]    lcr_q, thr_q, tsr_q, rx_sh_q, rhr_q;
  logic [4:0]    mcr_q;
  logic [3:0]    ier_q, pend_q, mst_q, delta_q, act, mst_now;
  logic [3:0]    isr_code;
  logic [15:0]   div_q, baud_cnt_q, div_m1;
  logic [5:0]    tx_tk_q, rx_tk_q, tx_last, rx_last;
  logic [2:0]    tx_bit_q, rx_bit_q;
  asc_ser_st_t   tx_st_q, rx_st_q;
  logic          thr_full_q, tx_par_q, ser, ser_brk, rx_line;
  logic          rx_prev_q, rx_zero_q, rx_pbad_q;
  logic          dr_q, oe_q, pe_q, fe_q, bi_q;
  logic          rd_evt, wr_evt, dlab, loop, tick, load;
  logic          tx_end, rx_smp, rx_done, accept, wr_thr;
  logic [2:0]    adr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // word length
  function automatic logic [2:0] last_bit(input logic [7:0] l);
    last_bit = 3'(l[1:0]) + 3'd4;
  endfunction

  function automatic logic exp_par(input logic [7:0] d,
                                   input logic [7:0] l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'd3 - l[1:0]));
    if (l[LCR_STK])
      exp_par = !l[LCR_EVN];
    else
      exp_par = l[LCR_EVN] ? ^m : ~^m;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_s1_q  <= BUS_IDLE;
      bus_s2_q  <= BUS_IDLE;
      mdm_s1_q  <= MDM_IDLE;
      mdm_s2_q  <= MDM_IDLE;
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rd_n_s3_q <= 1'b1;
      wr_n_s3_q <= 1'b1;
    end else if (ce_in) begin
      bus_s1_q  <= bus_in;
      bus_s2_q  <= bus_s1_q;
      mdm_s1_q  <= modem_in;
      mdm_s2_q  <= mdm_s1_q;
      rx_s1_q   <= rx_in;
      rx_s2_q   <= rx_s1_q;
      rd_n_s3_q <= bus_s2_q.rd_n;
      wr_n_s3_q <= bus_s2_q.wr_n;
    end
  end

  // Address and data settle with the strobe, so two stages suffice
  assign adr    = bus_s2_q.addr;
  assign rd_evt = ce_in && !bus_s2_q.cs_n && !bus_s2_q.rd_n
                  && rd_n_s3_q;
  assign wr_evt = ce_in && !bus_s2_q.cs_n && !bus_s2_q.wr_n
                  && wr_n_s3_q;
  assign dlab   = lcr_q[LCR_DLAB];
  assign loop   = mcr_q[MCR_LOOP];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lcr_q <= LCR_RST;
      mcr_q <= MCR_RST;
      ier_q <= IER_RST;
      div_q <= DIV_RST;
    end else if (wr_evt) begin
      case (adr)
        A_DATA: if (dlab) div_q[7:0] <= bus_s2_q.data;
        A_IER: begin
          if (dlab)
            div_q[15:8] <= bus_s2_q.data;
          else
            ier_q <= bus_s2_q.data[3:0];
        end
        A_LCR:   lcr_q <= bus_s2_q.data;
        A_MCR:   mcr_q <= bus_s2_q.data[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // 16x baud tick
  // ----------------------------------------------------------------
  assign div_m1 = (div_q == 16'h0000) ? 16'h0000 : 16'(div_q - 16'h1);
  assign tick   = ce_in && (baud_cnt_q >= div_m1);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in)
      baud_cnt_q <= 16'h0000;
    else if (ce_in)
      baud_cnt_q <= tick ? 16'h0000 : 16'(baud_cnt_q + 16'h1);
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Writes meeting a full holding register and busy shifter are lost
  assign wr_thr = wr_evt && adr == A_DATA && !dlab
                  && (!thr_full_q || load);
  assign load   = ce_in && tx_st_q == S_IDLE && thr_full_q;
  assign tx_last = (tx_st_q != S_STOP) ? 6'(TK_BIT - 6'd1) :
                   !lcr_q[LCR_STB] ? 6'(TK_BIT - 6'd1) :
                   (lcr_q[1:0] == 2'b00) ? 6'(TK_ST15 - 6'd1) :
                   6'(TK_ST2 - 6'd1);
  assign tx_end = tick && tx_tk_q == tx_last;

  always_comb begin
    case (tx_st_q)
      S_START: ser = 1'b0;
      S_DATA:  ser = tsr_q[tx_bit_q];
      S_PAR:   ser = tx_par_q;
      default: ser = 1'b1;
    endcase
  end
  assign ser_brk = ser && !lcr_q[LCR_BRK];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_thr)
        thr_q <= bus_s2_q.data;
      thr_full_q <= wr_thr || (thr_full_q && !load);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_st_q  <= S_IDLE;
      tsr_q    <= 8'h00;
      tx_par_q <= 1'b0;
      tx_tk_q  <= 6'h00;
      tx_bit_q <= 3'h0;
    end else if (ce_in) begin
      if (tick)
        tx_tk_q <= tx_end ? 6'h00 : 6'(tx_tk_q + 6'h1);
      case (tx_st_q)
        S_IDLE: begin
          if (load) begin
            tsr_q    <= thr_q;
            tx_par_q <= exp_par(thr_q, lcr_q);
            tx_tk_q  <= 6'h00;
            tx_st_q  <= S_START;
          end
        end
        S_START: begin
          if (tx_end) begin
            tx_bit_q <= 3'h0;
            tx_st_q  <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_end) begin
            if (tx_bit_q == last_bit(lcr_q))
              tx_st_q <= lcr_q[LCR_PEN] ? S_PAR : S_STOP;
            else
              tx_bit_q <= 3'(tx_bit_q + 3'h1);
          end
        end
        S_PAR:   if (tx_end) tx_st_q <= S_STOP;
        S_STOP:  if (tx_end) tx_st_q <= S_IDLE;
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // internal loop
  assign rx_line = loop ? ser_brk : rx_s2_q;
  assign rx_last = (rx_st_q == S_START) ? TK_MID : 6'(TK_BIT - 6'd1);
  assign rx_smp  = tick && rx_st_q != S_IDLE && rx_tk_q == rx_last;
  assign rx_done = rx_smp && rx_st_q == S_STOP;
  assign accept  = rx_done && (!dr_q || (rd_evt && adr == A_DATA
                                         && !dlab));

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_st_q   <= S_IDLE;
      rx_prev_q <= 1'b1;
      rx_tk_q   <= 6'h00;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_zero_q <= 1'b0;
      rx_pbad_q <= 1'b0;
    end else if (ce_in) begin
      rx_prev_q <= rx_line;
      if (tick)
        rx_tk_q <= rx_smp ? 6'h00 : 6'(rx_tk_q + 6'h1);
      case (rx_st_q)
        S_IDLE: begin
          if (rx_prev_q && !rx_line) begin
            rx_tk_q <= 6'h00;
            rx_st_q <= S_START;
          end
        end
        S_START: begin
          if (rx_smp) begin
            rx_st_q   <= rx_line ? S_IDLE : S_DATA;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_zero_q <= 1'b1;
            rx_pbad_q <= 1'b0;
          end
        end
        S_DATA: begin
          if (rx_smp) begin
            rx_sh_q[rx_bit_q] <= rx_line;
            rx_zero_q         <= rx_zero_q && !rx_line;
            if (rx_bit_q == last_bit(lcr_q))
              rx_st_q <= lcr_q[LCR_PEN] ? S_PAR : S_STOP;
            else
              rx_bit_q <= 3'(rx_bit_q + 3'h1);
          end
        end
        S_PAR: begin
          if (rx_smp) begin
            rx_pbad_q <= rx_line != exp_par(rx_sh_q, lcr_q);
            rx_zero_q <= rx_zero_q && !rx_line;
            rx_st_q   <= S_STOP;
          end
        end
        S_STOP:  if (rx_smp) rx_st_q <= S_IDLE;
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rhr_q <= 8'h00;
      dr_q  <= 1'b0;
      oe_q  <= 1'b0;
      pe_q  <= 1'b0;
      fe_q  <= 1'b0;
      bi_q  <= 1'b0;
    end else if (ce_in) begin
      if (accept)
        rhr_q <= rx_sh_q;
      dr_q <= accept || (dr_q && !(rd_evt && adr == A_DATA && !dlab));
      oe_q <= (rx_done && !accept)
              || (oe_q && !(rd_evt && adr == A_LSR));
      pe_q <= (rx_done && lcr_q[LCR_PEN] && rx_pbad_q)
              || (pe_q && !(rd_evt && adr == A_LSR));
      fe_q <= (rx_done && !rx_line)
              || (fe_q && !(rd_evt && adr == A_LSR));
      bi_q <= (rx_done && rx_zero_q && !rx_line)
              || (bi_q && !(rd_evt && adr == A_LSR));
    end
  end

  // ----------------------------------------------------------------
  // Modem status
  // ----------------------------------------------------------------
  // status sources
  assign mst_now = loop ? {mcr_q[MCR_OUT], mcr_q[MCR_RIL],
                           mcr_q[MCR_DTR], mcr_q[MCR_RTS]}
                        : ~mdm_s2_q;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mst_q   <= 4'h0;
      delta_q <= 4'h0;
    end else if (ce_in) begin
      mst_q   <= mst_now;
      delta_q <= (mst_now ^ mst_q)
                 | (delta_q & {4{!(rd_evt && adr == A_MSR)}});
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  // source masks
  assign act = pend_q & ier_q;

  always_comb begin
    if (act[IE_LSR])
      isr_code = ISR_LSR;
    else if (act[IE_RX])
      isr_code = ISR_RXR;
    else if (act[IE_THR])
      isr_code = ISR_THR;
    else if (act[IE_MSR])
      isr_code = ISR_MSR;
    else
      isr_code = ISR_NONE;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_q <= 4'h0;
    end else if (ce_in) begin
      pend_q[IE_LSR] <= (rx_done && (!accept || !rx_line
                         || (lcr_q[LCR_PEN] && rx_pbad_q)))
                        || (pend_q[IE_LSR] && !(rd_evt
                        && (adr == A_LSR || (adr == A_ISR
                        && isr_code == ISR_LSR))));
      pend_q[IE_RX]  <= accept || (pend_q[IE_RX] && !(rd_evt
                        && ((adr == A_DATA && !dlab) || (adr == A_ISR
                        && isr_code == ISR_RXR))));
      // empty raises interrupt
      // Enabling the source while the holding register is empty raises it
      pend_q[IE_THR] <= load || (wr_evt && adr == A_IER && !dlab
                        && bus_s2_q.data[IE_THR] && !thr_full_q)
                        || (pend_q[IE_THR] && !wr_thr
                        && !(rd_evt && adr == A_ISR
                        && isr_code == ISR_THR));
      pend_q[IE_MSR] <= (|(mst_now ^ mst_q))
                        || (pend_q[IE_MSR] && !(rd_evt
                        && (adr == A_MSR || (adr == A_ISR
                        && isr_code == ISR_MSR && act[IE_MSR]))));
    end
  end

  // ----------------------------------------------------------------
  // Read port and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out      <= 8'h00;
      data_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      data_oe_n_out <= bus_s2_q.cs_n || bus_s2_q.rd_n;
      if (rd_evt) begin
        case (adr)
          A_DATA:  data_out <= dlab ? div_q[7:0] : rhr_q;
          A_IER:   data_out <= dlab ? div_q[15:8] : {4'h0, ier_q};
          A_ISR:   data_out <= {4'h0, isr_code};
          A_LCR:   data_out <= lcr_q;
          A_MCR:   data_out <= {3'h0, mcr_q};
          A_LSR:   data_out <= {1'b0, !thr_full_q && tx_st_q == S_IDLE,
                                !thr_full_q, bi_q, fe_q, pe_q, oe_q,
                                dr_q};
          A_MSR:   data_out <= {mst_now, delta_q};
          default: data_out <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_out       <= 1'b1;
      dtr_n_out    <= 1'b1;
      rts_n_out    <= 1'b1;
      int_out      <= 1'b0;
      int_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      tx_out       <= loop || ser_brk;
      dtr_n_out    <= !mcr_q[MCR_DTR];
      rts_n_out    <= !mcr_q[MCR_RTS];
      int_out      <= |act;
      int_oe_n_out <= !mcr_q[MCR_OUT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence s_false_start;
    rx_st_q == S_START && rx_smp && rx_line;
  endsequence
  sequence s_full_arrive;
    rx_done && dr_q && !(rd_evt && adr == A_DATA);
  endsequence

  AST_FALSE_START: assert property (
    s_false_start |=> rx_st_q == S_IDLE)
    else $error("false start not dropped");
  AST_OVERRUN: assert property (
    s_full_arrive |=> oe_q && rhr_q == $past(rhr_q))
    else $error("overrun mishandled");
  AST_ISR_TOP: assert property (
    act[IE_LSR] |-> isr_code == 4'h6)
    else $error("line status not top");
  AST_ISR_RX: assert property (
    !act[IE_LSR] && act[IE_RX] |-> isr_code == 4'h4)
    else $error("receive code wrong");
  AST_ISR_IDLE: assert property (
    act == 4'h0 |-> isr_code == 4'h1)
    else $error("idle code wrong");
  AST_BREAK: assert property (
    ce_in && lcr_q[6] && !mcr_q[4] |=> !tx_out)
    else $error("break not driven");
  AST_LOOP_PIN: assert property (
    ce_in && mcr_q[4] |=> tx_out)
    else $error("loop pin not high");
  AST_DTR: assert property (
    ce_in |=> dtr_n_out == !$past(mcr_q[0]))
    else $error("dtr polarity wrong");
  AST_INT_OE: assert property (
    ce_in |=> int_oe_n_out == !$past(mcr_q[3]))
    else $error("int enable wrong");
  AST_MSR_CLR: assert property (
    ce_in && rd_evt && adr == A_MSR && mst_now == mst_q
    |=> delta_q == 4'h0)
    else $error("deltas not cleared");
endmodule

// >>> rtl/asc_pkg.sv
// Purpose: shared constants and types for one async serial channel
// Assumes: one 250 MHz system clock, 8-bit register port
// Notes:   register offsets follow the three address pins
package asc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_ISR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LCR_STB  = 2;
  localparam int LCR_PEN  = 3;
  localparam int LCR_EVN  = 4;
  localparam int LCR_STK  = 5;
  localparam int LCR_BRK  = 6;
  localparam int LCR_DLAB = 7;
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_RIL  = 2;
  localparam int MCR_OUT  = 3;
  localparam int MCR_LOOP = 4;
  localparam int IE_RX    = 0;
  localparam int IE_THR   = 1;
  localparam int IE_LSR   = 2;
  localparam int IE_MSR   = 3;
  // ----------------------------------------------------------------
  // Interrupt codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LSR  = 4'h6;
  localparam logic [3:0] ISR_RXR  = 4'h4;
  localparam logic [3:0] ISR_THR  = 4'h2;
  localparam logic [3:0] ISR_MSR  = 4'h0;
  localparam logic [7:0] LCR_RST  = 8'h00;
  localparam logic [4:0] MCR_RST  = 5'h00;
  localparam logic [3:0] IER_RST  = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // ----------------------------------------------------------------
  // Timing counts in 16x ticks
  // ----------------------------------------------------------------
  localparam logic [5:0] TK_BIT  = 6'd16;
  localparam logic [5:0] TK_MID  = 6'd7;
  localparam logic [5:0] TK_ST15 = 6'd24;
  localparam logic [5:0] TK_ST2  = 6'd32;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } asc_bus_in_t;
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } asc_modem_in_t;
  localparam asc_bus_in_t   BUS_IDLE = 14'h3800;
  localparam asc_modem_in_t MDM_IDLE = 4'hF;
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_DATA, S_PAR, S_STOP
  } asc_ser_st_t;
endpackage

// >>> verif/asc_peer.sv
// Purpose: far-side serial peer of one async channel
// Assumes: divisor stays 1, so one bit lasts 16 clocks
// Notes:   drives rx and modem lines, samples tx frames
`timescale 1ns/1ps
module asc_peer (
  input  wire logic              clk_in,
  input  wire logic              tx_in,
  output logic                   rx_out,
  output asc_pkg::asc_modem_in_t modem_out
);
  import asc_pkg::*;
  initial begin
    rx_out    = 1'b1;
    modem_out = MDM_IDLE;
  end
  // --------------------
  // Line drivers
  // --------------------
  task automatic bit_out(input logic b);
    @(posedge clk_in);
    #1 rx_out = b;
    repeat (15) @(posedge clk_in);
  endtask
  task automatic send(input logic [7:0] d, input int n, input logic pen,
                      input logic par, input logic stp);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (pen) bit_out(par);
    bit_out(stp);
    bit_out(1'b1);
  endtask
  // Too short to pass the mid-bit start check
  task automatic glitch();
    bit_out(1'b1);
    #1 rx_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 rx_out = 1'b1;
  endtask
  task automatic set_modem(input asc_modem_in_t m);
    @(posedge clk_in);
    #1 modem_out = m;
  endtask
  // Bounded wait for a start bit, then sample mid-bit
  task automatic catch(output logic [11:0] f);
    int n;
    n = 0;
    while (tx_in === 1'b1 && n < 4000) begin
      @(posedge clk_in);
      #1 n++;
    end
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 12; i++) begin
      repeat (16) @(posedge clk_in);
      #1 f[i] = tx_in;
    end
  endtask
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench for one async serial channel
// Assumes: divisor left at 1, so one serial bit is 16 clocks
// Notes:   strobes held 6 clocks low and 4 high, past the synchroniser
`timescale 1ns/1ps
module tb_top;
  import asc_pkg::*;
  logic          clk_sys_in;
  logic          resetn_in;
  asc_bus_in_t   bus;
  asc_modem_in_t mdm;
  logic [7:0]    dout;
  logic [7:0]    rd;
  logic [11:0]   fr;
  logic          tx;
  logic          rx;
  logic          dtr_n;
  logic          rts_n;
  logic          irq;
  logic          irq_oe_n;
  logic          ce;
  logic          doe_n;
  logic          oe;
  int            err_total;
  int            comparisons;
  int            lo;
  logic [7:0]    lcrs [8] = '{8'h03, 8'h1B, 8'h0B, 8'h2B,
                              8'h3B, 8'h00, 8'h01, 8'h06};
  asc_chan i_asc_chan (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce),
    .bus_in        (bus),
    .data_out      (dout),
    .data_oe_n_out (doe_n),
    .rx_in         (rx),
    .tx_out        (tx),
    .modem_in      (mdm),
    .dtr_n_out     (dtr_n),
    .rts_n_out     (rts_n),
    .int_out       (irq),
    .int_oe_n_out  (irq_oe_n)
  );
  asc_peer i_asc_peer (.clk_in(clk_sys_in), .tx_in(tx), .rx_out(rx),
                       .modem_out(mdm));
  // --------------------
  // Tasks
  // --------------------
  task automatic cmp(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1 bus = {1'b0, w, ~w, a, d};
    repeat (6) @(posedge clk_sys_in);
    #1 rd = dout;
    oe = doe_n;
    bus = BUS_IDLE;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic chk(input logic [2:0] a, input logic [7:0] e, string nm);
    acc(1'b0, a, 8'h00);
    cmp(nm, 12'(e), 12'(rd));
  endtask
  function automatic logic par(input logic [7:0] l, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hFF >> (2'd3 - l[1:0]));
    if (l[LCR_STK]) return ~l[LCR_EVN];
    return l[LCR_EVN] ? ^m : ~^m;
  endfunction
  function automatic logic [11:0] frame(input logic [7:0] l,
                                        input logic [7:0] d);
    logic [11:0] f;
    int          n;
    n = 5 + l[1:0];
    f = 12'hFFF;
    for (int i = 0; i < n; i++) f[i] = d[i];
    if (l[LCR_PEN]) f[n] = par(l, d);
    return f;
  endfunction
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // --------------------
  // Clock, watchdog, tests
  // --------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    err_total   = 0;
    comparisons = 0;
    bus         = BUS_IDLE;
    ce          = 1'b1;
    resetn_in   = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    chk(A_ISR, 8'h01, "isr");
    cmp("oe_n rd", 12'h0, 12'(oe));
    chk(A_LCR, 8'h00, "lcr");
    chk(A_LSR, 8'h60, "lsr");
    cmp("dtr_rts", 12'h3, 12'({dtr_n, rts_n}));
    cmp("int_oe_n", 12'h1, 12'(irq_oe_n));
    wr(A_MCR, 8'h0B);
    cmp("oe_n wr", 12'h1, 12'(oe));
    cmp("dtr_rts", 12'h0, 12'({dtr_n, rts_n}));
    cmp("int_oe_n", 12'h0, 12'(irq_oe_n));
    wr(A_IER, 8'h0F);
    i_asc_peer.set_modem(4'hE);
    wr(A_LCR, 8'h1B);
    wr(A_DATA, 8'h55);
    i_asc_peer.send(8'h96, 8, 1'b1, ~par(8'h1B, 8'h96), 1'b1);
    cmp("int", 12'h1, 12'(irq));
    chk(A_ISR, 8'h06, "isr lsr");
    chk(A_ISR, 8'h04, "isr rx");
    chk(A_ISR, 8'h02, "isr thr");
    chk(A_ISR, 8'h00, "isr msr");
    chk(A_ISR, 8'h01, "isr none");
    cmp("int", 12'h0, 12'(irq));
    chk(A_LSR, 8'h65, "lsr pe");
    chk(A_DATA, 8'h96, "rhr");
    chk(A_MSR, 8'h11, "msr");
    chk(A_MSR, 8'h10, "msr clr");
    i_asc_peer.set_modem(MDM_IDLE);
    wr(A_LCR, 8'h03);
    i_asc_peer.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    chk(A_LSR, 8'h61, "lsr dr");
    chk(A_DATA, 8'hA5, "rhr");
    i_asc_peer.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    i_asc_peer.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
    chk(A_LSR, 8'h63, "lsr oe");
    chk(A_DATA, 8'h11, "rhr kept");
    i_asc_peer.send(8'h5A, 8, 1'b0, 1'b0, 1'b0);
    chk(A_LSR, 8'h69, "lsr fe");
    chk(A_DATA, 8'h5A, "rhr fe");
    i_asc_peer.glitch();
    repeat (250) @(posedge clk_sys_in);
    chk(A_LSR, 8'h60, "lsr false start");
    i_asc_peer.send(8'h00, 8, 1'b0, 1'b0, 1'b0);
    acc(1'b0, A_LSR, 8'h00);
    cmp("lsr bi", 12'h10, 12'(rd & 8'h10));
    acc(1'b0, A_DATA, 8'h00);
    foreach (lcrs[k]) begin
      wr(A_LCR, lcrs[k]);
      chk(A_LCR, lcrs[k], "lcr rw");
      fork
        i_asc_peer.catch(fr);
        wr(A_DATA, 8'hC6);
      join
      cmp("frame", frame(lcrs[k], 8'hC6), fr);
    end
    wr(A_DATA, 8'h0F);
    acc(1'b0, A_LSR, 8'h00);
    cmp("lsr busy", 12'h20, 12'(rd & 8'h60));
    repeat (250) @(posedge clk_sys_in);
    wr(A_LCR, 8'h43);
    cmp("tx brk", 12'h0, 12'(tx));
    wr(A_LCR, 8'h83);
    cmp("tx idle", 12'h1, 12'(tx));
    wr(A_DATA, 8'h01);
    wr(A_IER, 8'h00);
    chk(A_DATA, 8'h01, "div lo");
    chk(A_IER, 8'h00, "div hi");
    chk(A_LCR, 8'h83, "lcr dlab");
    wr(A_LCR, 8'h03);
    #1 ce = 1'b0;
    wr(A_LCR, 8'h1F);
    #1 ce = 1'b1;
    chk(A_LCR, 8'h03, "lcr frozen");
    chk(A_IER, 8'h0F, "ier");
    wr(A_MCR, 8'hFF);
    chk(A_MCR, 8'h1F, "mcr");
    acc(1'b0, A_MSR, 8'h00);
    cmp("msr loop", 12'hF0, 12'(rd & 8'hF0));
    wr(A_DATA, 8'h3C);
    lo = 0;
    repeat (250) begin
      @(posedge clk_sys_in);
      lo += (tx !== 1'b1);
    end
    cmp("tx loop", 12'h0, 12'(lo));
    chk(A_DATA, 8'h3C, "loop rx");
    tally_and_finish();
  end
endmodule
